// File: rtl/icache_pkg.sv
// Package for the instruction cache with preloadable RAM sets.
// Assumes a 24-bit byte fetch address and a 32-bit word memory port.
package icache_pkg;

  // Fetch address fields
  localparam int ADDR_W      = 24;
  localparam int WORD_W      = 32;
  localparam int TW_TAG_LSB  = 13;
  localparam int TW_TAG_W    = 11;
  localparam int TW_IDX_LSB  = 4;
  localparam int TW_IDX_W    = 9;
  localparam int RS_TAG_LSB  = 12;
  localparam int RS_TAG_W    = 12;
  localparam int RS_IDX_LSB  = 4;
  localparam int RS_IDX_W    = 8;
  localparam int OFS_LSB     = 2;
  localparam int OFS_W       = 2;
  localparam int LINE_WORDS  = 4;
  localparam int TW_LINES    = 512;
  localparam int RS_LINES    = 256;
  localparam int RS_MAX      = 2;

  // Register map (word offsets on the register port)
  localparam logic [3:0] REG_CONFIG     = 4'h0;
  localparam logic [3:0] REG_TW_CTRL    = 4'h1;
  localparam logic [3:0] REG_RS1_CTRL   = 4'h2;
  localparam logic [3:0] REG_RS2_CTRL   = 4'h3;
  localparam logic [3:0] REG_RS1_TAG    = 4'h4;
  localparam logic [3:0] REG_RS2_TAG    = 4'h5;
  localparam logic [3:0] REG_STATUS     = 4'h6;
  localparam logic [3:0] REG_CORE_STAT  = 4'h7;

  // Field positions
  localparam int CFG_RS_CNT_LSB = 0;
  localparam int RS_CTRL_OK_BIT = 15;
  localparam int CORE_EN_BIT    = 14;
  localparam int CORE_FLUSH_BIT = 13;
  localparam int STAT_EN_BIT    = 0;
  localparam int STAT_BUSY_BIT  = 1;

  // Reset values
  localparam logic [1:0]  CFG_RS_CNT_RST = 2'h0;
  localparam logic [15:0] REG_RST        = 16'h0000;

  // Fetch request toward the cache
  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } fetch_req_type;

  // Word request toward external memory
  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } mem_req_type;

endpackage

// File: rtl/icache_ramset.sv
// Instruction cache: 16KB two-way cache plus up to two 4KB RAM sets.
// Assumes a fetch unit holding one request until fetch_ack and a memory
// port that answers each one-cycle word request with one mem_ack pulse.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module icache_ramset (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // Register port
  input  wire logic [3:0]                      reg_addr,
  input  wire logic [15:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output var  logic [15:0]                     reg_rdata,
  // Core fetch port
  input  wire icache_pkg::fetch_req_type       fetch_in,
  output var  logic                            fetch_ack,
  output var  logic [icache_pkg::WORD_W-1:0]   fetch_data,
  // External memory port
  output var  icache_pkg::mem_req_type         mem_out,
  input  wire logic                            mem_ack,
  input  wire logic [icache_pkg::WORD_W-1:0]   mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and state
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BYP   = 5'b00010,
    ST_FILL  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_PRE   = 5'b10000
  } state_type;

  localparam int AW = icache_pkg::ADDR_W;
  localparam int WW = icache_pkg::WORD_W;

  // Flip-flop storage addressed by index
  logic [WW-1:0]                    tw_data [2][icache_pkg::TW_LINES*4];
  logic [icache_pkg::TW_TAG_W-1:0]  tw_tag  [2][icache_pkg::TW_LINES];
  logic [icache_pkg::TW_LINES-1:0]  tw_valid [2];
  logic [icache_pkg::TW_LINES-1:0]  lru_reg;      // Way to replace next
  logic [WW-1:0]                    rs_data [2][icache_pkg::RS_LINES*4];
  logic [icache_pkg::RS_LINES-1:0]  rs_valid [2];
  logic [icache_pkg::RS_TAG_W-1:0]  rs_tag_reg [2];
  logic [1:0]                       rs_ok_reg;    // Tag-ok flags

  // Registers
  logic [1:0]  rs_cnt_reg;        // Number of RAM sets in use
  logic [15:0] tw_ctrl_reg;       // Two-way control word
  logic [15:0] rs_ctrl_reg [2];   // RAM set control words
  logic        enable_reg;        // Cache enable
  logic        en_stat_reg;       // Enabled status seen by software

  // Sequencer
  state_type    state_reg;
  logic [1:0]   cnt_reg;           // Word counter within a line
  logic [7:0]   pre_line_reg;      // Preload line counter
  logic         pre_set_reg;       // RAM set being preloaded
  logic [AW-1:0] base_reg;         // Line base address for fill
  logic         fill_rs_reg;       // Fill target is a RAM set
  logic         fill_way_reg;      // Fill target way or RAM set
  logic         sent_reg;          // Requested word already delivered
  logic         req_pend_reg;      // Preload word requested

  // Reset synchroniser
  logic rst_s1, rst_s2;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire logic rst_l = rst_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic [AW-1:0] fa = fetch_in.addr;
  wire logic [icache_pkg::TW_TAG_W-1:0] f_twtag =
    fa[icache_pkg::TW_TAG_LSB +: icache_pkg::TW_TAG_W];
  wire logic [icache_pkg::TW_IDX_W-1:0] f_set =
    fa[icache_pkg::TW_IDX_LSB +: icache_pkg::TW_IDX_W];
  wire logic [icache_pkg::RS_TAG_W-1:0] f_rstag =
    fa[icache_pkg::RS_TAG_LSB +: icache_pkg::RS_TAG_W];
  wire logic [icache_pkg::RS_IDX_W-1:0] f_rsline =
    fa[icache_pkg::RS_IDX_LSB +: icache_pkg::RS_IDX_W];
  wire logic [icache_pkg::OFS_W-1:0] f_ofs =
    fa[icache_pkg::OFS_LSB +: icache_pkg::OFS_W];
  wire logic [10:0] tw_widx = {f_set, f_ofs};
  wire logic [9:0]  rs_widx = {f_rsline, f_ofs};

  // Presence check in both ways
  logic [1:0] tw_hit;
  logic [1:0] rs_hit;
  logic [1:0] rs_tagm;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_look
      assign tw_hit[g] = tw_valid[g][f_set] && (tw_tag[g][f_set] == f_twtag);
      // RAM set counts only when configured
      assign rs_tagm[g] = (rs_cnt_reg > 2'(g)) && rs_ok_reg[g] &&
                          (rs_tag_reg[g] == f_rstag);
      assign rs_hit[g] = rs_tagm[g] && rs_valid[g][f_rsline];
    end
  endgenerate

  wire logic any_rs_hit = |rs_hit;
  wire logic rs_sel     = !rs_hit[0];
  wire logic tw_sel     = !tw_hit[0];
  wire logic any_tw_hit = |tw_hit;
  wire logic any_tagm   = |rs_tagm;
  wire logic tagm_sel   = !rs_tagm[0];
  wire logic [WW-1:0] hit_word = any_rs_hit ? rs_data[rs_sel][rs_widx]
                                            : tw_data[tw_sel][tw_widx];
  wire logic idle_req   = (state_reg == ST_IDLE) && fetch_in.req && !fetch_ack;
  // A RAM set tag match outranks a two-way hit, so that RAM set line is loaded
  wire logic tw_use     = any_tw_hit && !any_tagm;
  wire logic do_hit     = idle_req && enable_reg && (any_rs_hit || tw_use);
  wire logic do_miss    = idle_req && enable_reg && !any_rs_hit && !tw_use;
  wire logic do_byp     = idle_req && !enable_reg;
  wire logic flush      = reg_wr && (reg_addr == icache_pkg::REG_CORE_STAT) &&
                          reg_wdata[icache_pkg::CORE_FLUSH_BIT];
  wire logic tag_wr0    = reg_wr && (reg_addr == icache_pkg::REG_RS1_TAG);
  wire logic tag_wr1    = reg_wr && (reg_addr == icache_pkg::REG_RS2_TAG);
  wire logic [1:0] ofs_now = cnt_reg;
  wire logic word_in    = mem_ack && (state_reg == ST_FILL);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      rs_cnt_reg     <= icache_pkg::CFG_RS_CNT_RST;
      tw_ctrl_reg    <= icache_pkg::REG_RST;
      rs_ctrl_reg[0] <= icache_pkg::REG_RST;
      rs_ctrl_reg[1] <= icache_pkg::REG_RST;
      enable_reg     <= 1'b0;
      en_stat_reg    <= 1'b0;
      rs_tag_reg[0]  <= '0;
      rs_tag_reg[1]  <= '0;
    end else begin
      en_stat_reg <= enable_reg;
      if (reg_wr) begin
        unique case (reg_addr)
          icache_pkg::REG_CONFIG: begin
            // Values above two fall back to two RAM sets
            rs_cnt_reg <= (reg_wdata[1:0] == 2'h3) ? 2'h2 : reg_wdata[1:0];
          end
          icache_pkg::REG_TW_CTRL:   tw_ctrl_reg    <= reg_wdata;
          icache_pkg::REG_RS1_CTRL:  rs_ctrl_reg[0] <= reg_wdata;
          icache_pkg::REG_RS2_CTRL:  rs_ctrl_reg[1] <= reg_wdata;
          icache_pkg::REG_RS1_TAG:   rs_tag_reg[0]  <= reg_wdata[11:0];
          icache_pkg::REG_RS2_TAG:   rs_tag_reg[1]  <= reg_wdata[11:0];
          icache_pkg::REG_CORE_STAT: enable_reg     <= reg_wdata[icache_pkg::CORE_EN_BIT];
          default: begin
          end
        endcase
      end
    end
  end

  // Read mux, data one cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      icache_pkg::REG_CONFIG:    rd_mux = {14'h0000, rs_cnt_reg};
      icache_pkg::REG_TW_CTRL:   rd_mux = tw_ctrl_reg;
      icache_pkg::REG_RS1_CTRL:  rd_mux = {rs_ok_reg[0], rs_ctrl_reg[0][14:0]};
      icache_pkg::REG_RS2_CTRL:  rd_mux = {rs_ok_reg[1], rs_ctrl_reg[1][14:0]};
      icache_pkg::REG_RS1_TAG:   rd_mux = {4'h0, rs_tag_reg[0]};
      icache_pkg::REG_RS2_TAG:   rd_mux = {4'h0, rs_tag_reg[1]};
      icache_pkg::REG_STATUS:    rd_mux = {14'h0000, state_reg == ST_PRE, en_stat_reg};
      icache_pkg::REG_CORE_STAT: rd_mux = {1'b0, enable_reg, 14'h0000};
      default:                   rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: bypass, line fill and RAM set preload
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 2'h0;
      pre_line_reg <= 8'h00;
      pre_set_reg  <= 1'b0;
      base_reg     <= '0;
      fill_rs_reg  <= 1'b0;
      fill_way_reg <= 1'b0;
      sent_reg     <= 1'b0;
      req_pend_reg <= 1'b0;
      rs_ok_reg    <= 2'b00;
      mem_out      <= '0;
      fetch_ack    <= 1'b0;
      fetch_data   <= '0;
    end else begin
      fetch_ack   <= 1'b0;
      mem_out.req <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          // Tag write preloads first; core fetch waits
          if (tag_wr0 || tag_wr1) begin
            pre_set_reg           <= tag_wr1;
            rs_ok_reg[tag_wr1]    <= 1'b0;
            pre_line_reg          <= 8'h00;
            cnt_reg               <= 2'h0;
            req_pend_reg          <= 1'b0;
            state_reg             <= ST_PRE;
          end else if (do_hit) begin
            fetch_ack  <= 1'b1;
            fetch_data <= hit_word;
          end else if (do_byp) begin
            mem_out.req  <= 1'b1;
            mem_out.addr <= {fa[AW-1:2], 2'b00};
            state_reg    <= ST_BYP;
          end else if (do_miss) begin
            base_reg     <= {fa[AW-1:4], 4'h0};
            fill_rs_reg  <= any_tagm;
            fill_way_reg <= any_tagm ? tagm_sel : lru_reg[f_set];
            cnt_reg      <= 2'h0;
            sent_reg     <= 1'b0;
            mem_out.req  <= 1'b1;
            mem_out.addr <= {fa[AW-1:4], 4'h0};
            state_reg    <= ST_FILL;
          end
        end
        ST_BYP: begin
          if (mem_ack) begin
            fetch_ack  <= 1'b1;
            fetch_data <= mem_rdata;
            state_reg  <= ST_WAIT;
          end
        end
        ST_FILL: begin
          if (mem_ack) begin
            if (!sent_reg && (cnt_reg == f_ofs)) begin
              fetch_ack  <= 1'b1;
              fetch_data <= mem_rdata;
              sent_reg   <= 1'b1;
            end
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
              state_reg <= ST_WAIT;
            end else begin
              mem_out.req  <= 1'b1;
              mem_out.addr <= {base_reg[AW-1:4], cnt_reg + 2'h1, 2'b00};
            end
          end
        end
        ST_WAIT: begin
          // Lets the core drop its request before the next lookup
          state_reg <= ST_IDLE;
        end
        ST_PRE: begin
          if (!req_pend_reg) begin
            mem_out.req  <= 1'b1;
            mem_out.addr <= {rs_tag_reg[pre_set_reg], pre_line_reg, cnt_reg, 2'b00};
            req_pend_reg <= 1'b1;
          end else if (mem_ack) begin
            req_pend_reg <= 1'b0;
            cnt_reg      <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
              pre_line_reg <= pre_line_reg + 8'h01;
              if (pre_line_reg == 8'hFF) begin
                rs_ok_reg[pre_set_reg] <= 1'b1;
                state_reg              <= ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array writes, valid bits and LRU
  wire logic [1:0] fill_ofs = (state_reg == ST_PRE) ? cnt_reg : ofs_now;
  wire logic pre_word = (state_reg == ST_PRE) && req_pend_reg && mem_ack;
  wire logic line_done = (word_in || pre_word) && (cnt_reg == 2'h3);

  always_ff @(posedge core_clk) begin
    // Words land one at a time
    if (word_in && !fill_rs_reg) begin
      tw_data[fill_way_reg][{base_reg[12:4], fill_ofs}] <= mem_rdata;
    end
    if (word_in && fill_rs_reg) begin
      rs_data[fill_way_reg][{base_reg[11:4], fill_ofs}] <= mem_rdata;
    end
    if (pre_word) begin
      rs_data[pre_set_reg][{pre_line_reg, fill_ofs}] <= mem_rdata;
    end
    if (line_done && (state_reg == ST_FILL) && !fill_rs_reg) begin
      tw_tag[fill_way_reg][base_reg[12:4]] <= base_reg[23:13];
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_valid
      always_ff @(posedge core_clk or negedge rst_l) begin
        if (!rst_l) begin
          tw_valid[g] <= '0;
          rs_valid[g] <= '0;
        end else begin
          // Flush clears first, so a line finishing in that cycle still validates
          if (flush) begin
            tw_valid[g] <= '0;
            rs_valid[g] <= '0;
          end
          // Valid only after the whole line
          if (line_done && (state_reg == ST_FILL) && !fill_rs_reg &&
              (fill_way_reg == 1'(g))) begin
            tw_valid[g][base_reg[12:4]] <= 1'b1;
          end
          if (line_done && (state_reg == ST_FILL) && fill_rs_reg &&
              (fill_way_reg == 1'(g))) begin
            rs_valid[g][base_reg[11:4]] <= 1'b1;
          end
          if (line_done && (state_reg == ST_PRE) && (pre_set_reg == 1'(g))) begin
            rs_valid[g][pre_line_reg] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // LRU points away from the way just used
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      lru_reg <= '0;
    end else if (do_hit && !any_rs_hit) begin
      lru_reg[f_set] <= !tw_sel;
    end else if (line_done && (state_reg == ST_FILL) && !fill_rs_reg) begin
      lru_reg[base_reg[12:4]] <= !fill_way_reg;
    end
  end

endmodule

`default_nettype wire

// File: test/icache_sva.sv
// Checker for the instruction cache ports.
// Assumes one clock domain and the register map of the design package.
`timescale 1ns/10ps
`default_nettype none

module icache_sva (
  // Clock and reset
  input wire logic                          core_clk,
  input wire logic                          rst_n,
  // Register port
  input wire logic [3:0]                    reg_addr,
  input wire logic [15:0]                   reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [15:0]                   reg_rdata,
  // Fetch and memory ports
  input wire icache_pkg::fetch_req_type     fetch_in,
  input wire logic                          fetch_ack,
  input wire logic [icache_pkg::WORD_W-1:0] fetch_data,
  input wire icache_pkg::mem_req_type       mem_out,
  input wire logic                          mem_ack,
  input wire logic [icache_pkg::WORD_W-1:0] mem_rdata
);
  logic        en_q;   // Enable bit as last written
  logic [23:0] last_a; // Address of the word in flight
  logic [1:0]  out_n;  // Words requested and not yet answered

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////
  // Helper state, rebuilt from the ports only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      last_a <= '0;
      out_n  <= '0;
    end else begin
      if (reg_wr && reg_addr == icache_pkg::REG_CORE_STAT) begin
        en_q <= reg_wdata[icache_pkg::CORE_EN_BIT];
      end
      if (mem_out.req) begin
        last_a <= mem_out.addr;
      end
      // Saturates so a runaway never wraps back to a legal count
      out_n <= out_n + {1'b0, mem_out.req & (out_n != 2'h3)} - {1'b0, mem_ack & (out_n != 2'h0)};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Assertions
  AST_ACK_PULSE: assert property (fetch_ack |=> !fetch_ack)
    else $error("fetch ack longer than one cycle");
  AST_MEM_PULSE: assert property (mem_out.req |=> !mem_out.req)
    else $error("memory request longer than one cycle");
  AST_ONE_WORD: assert property (out_n <= 2'h1)
    else $error("more than one memory word outstanding");
  AST_ALIGN: assert property (mem_out.req |-> mem_out.addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  AST_FORWARD: assert property ($past(mem_ack && fetch_in.req
      && last_a[23:2] == fetch_in.addr[23:2]) |-> fetch_ack && fetch_data == $past(mem_rdata))
    else $error("requested word not forwarded the cycle after it arrived");
  AST_ACK_CAUSE: assert property (fetch_ack |-> $past(fetch_in.req))
    else $error("fetch ack without a request");
  AST_BYPASS: assert property (fetch_ack && !$past(en_q) |-> $past(mem_ack))
    else $error("disabled cache answered without memory");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the read answer cycle");
  AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr[3]) |-> reg_rdata == 16'h0000)
    else $error("unmapped register read not zero");
endmodule

bind icache_ramset icache_sva chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_in(fetch_in),
  .fetch_ack(fetch_ack), .fetch_data(fetch_data), .mem_out(mem_out),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// File: test/mem_model.sv
// External memory model answering one word per request, in order.
// Assumes byte addresses with the low two bits zero.
`timescale 1ns/10ps
`default_nettype none

module mem_model (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // Requests and answers
  input  wire icache_pkg::mem_req_type mem_out,
  output var  logic                    mem_ack,
  output var  logic [31:0]             mem_rdata,
  // Latency and content selection from the bench
  input  wire logic [3:0]              lat,
  input  wire logic                    alt
);
  logic [23:0] pend_q[$]; // Addresses waiting for an answer
  int          cnt;       // Cycles spent on the head request

  ////////////////////////////////////////////////////////////////
  // Answer after lat cycles; data inverts each idle cycle so a
  // stale sample never matches by chance
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt       = 0;
      pend_q.delete();
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req) pend_q.push_back(mem_out.addr);
      if (pend_q.size() > 0) begin
        if (cnt >= lat) begin
          // Content flag mimics a program memory rewrite
          mem_rdata <= {alt ? 8'hC3 : 8'h5A, pend_q.pop_front()};
          mem_ack   <= 1'b1;
          cnt       = 0;
        end else cnt++;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the instruction cache.
// Assumes the memory model content {8'h5A or 8'hC3, word address}.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                      core_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [3:0]                reg_addr, lat;
  logic [15:0]               reg_wdata, reg_rdata, v;
  logic                      reg_wr, reg_rd, fetch_ack, mem_ack, alt;
  logic [31:0]               fetch_data, mem_rdata;
  icache_pkg::fetch_req_type fetch_in;
  icache_pkg::mem_req_type   mem_out;
  int                        err_count, n_checks, mem_cnt, m0, i;

  always #10 core_clk = ~core_clk;
  // Count every word asked of memory
  always @(posedge core_clk) if (mem_out.req === 1'b1) mem_cnt++;

  icache_ramset dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_in(fetch_in), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mem_model mem_u (.core_clk(core_clk), .rst_n(rst_n), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat), .alt(alt));

  ////////////////////////////////////////////////////////////////
  // Tasks
  function automatic logic [31:0] ew(input logic [23:0] a, input logic b);
    return {b ? 8'hC3 : 8'h5A, a[23:2], 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Fetch, compare the word and the number of memory words used
  task automatic fetch(input logic [23:0] a, input logic [31:0] exp, input int nmem);
    m0 = mem_cnt;
    @(posedge core_clk);
    fetch_in <= '{req: 1'b1, addr: a};
    i = 0;
    do begin
      @(posedge core_clk);
      #1 i++;
    end while (fetch_ack !== 1'b1 && i < 5000);
    chk(fetch_ack, 1'b1, "fetch answered");
    chk(fetch_data, exp, "fetch data");
    // Request drops at the next edge, inside the cycle after the answer
    @(posedge core_clk);
    fetch_in.req <= 1'b0;
    for (i = 0; i < 400 && mem_cnt - m0 < nmem; i++) @(posedge core_clk);
    repeat (lat + 4) @(posedge core_clk);
    chk(mem_cnt - m0, nmem, "memory words");
  endtask
  task automatic preload(input logic [3:0] tr, input logic [3:0] cr, input logic [15:0] t);
    m0 = mem_cnt;
    wr(tr, t);
    rd(cr);
    chk(v[15], 1'b0, "tag ok during fill");
    for (i = 0; i < 4000 && v[15] !== 1'b1; i++) rd(cr);
    chk(v[15], 1'b1, "tag ok after fill");
    chk(mem_cnt - m0, 1024, "preload words");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, alt} = '0;
    fetch_in = '0;
    lat      = 4'h1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(icache_pkg::REG_CONFIG);
    chk(v, 16'h0000, "config reset");
    rd(icache_pkg::REG_STATUS);
    chk(v, 16'h0000, "status reset");
    wr(4'h9, 16'hFFFF);
    rd(4'h9);
    chk(v, 16'h0000, "unmapped");
    fetch(24'h123456, ew(24'h123456, 0), 1);
    $display("test reset and bypass done");
    // Bring-up order as software would do it
    wr(icache_pkg::REG_TW_CTRL, 16'h000F);
    wr(icache_pkg::REG_RS1_CTRL, 16'h000F);
    wr(icache_pkg::REG_CORE_STAT, 16'h4000);
    rd(icache_pkg::REG_STATUS);
    chk(v[0], 1'b1, "enabled");
    lat = 4'h3;
    fetch(24'h001238, ew(24'h001238, 0), 4);
    fetch(24'h001231, ew(24'h001231, 0), 0);
    $display("test miss and hit done");
    // Three tags on set 0: LRU keeps the one just used
    fetch(24'h002000, ew(24'h002000, 0), 4);
    fetch(24'h004000, ew(24'h004000, 0), 4);
    fetch(24'h002004, ew(24'h002004, 0), 0);
    fetch(24'h006000, ew(24'h006000, 0), 4);
    fetch(24'h00200C, ew(24'h00200C, 0), 0);
    fetch(24'h004008, ew(24'h004008, 0), 4);
    $display("test replacement done");
    alt = 1'b1;
    fetch(24'h002000, ew(24'h002000, 0), 0);
    wr(icache_pkg::REG_CORE_STAT, 16'h6000);
    fetch(24'h002000, ew(24'h002000, 1), 4);
    $display("test flush done");
    lat = 4'h0;
    wr(icache_pkg::REG_CONFIG, 16'h0002);
    wr(icache_pkg::REG_RS2_CTRL, 16'h000F);
    preload(icache_pkg::REG_RS1_TAG, icache_pkg::REG_RS1_CTRL, 16'h0801);
    preload(icache_pkg::REG_RS2_TAG, icache_pkg::REG_RS2_CTRL, 16'h0802);
    fetch(24'h8010C4, ew(24'h8010C4, 1), 0);
    fetch(24'h802FF8, ew(24'h802FF8, 1), 0);
    wr(icache_pkg::REG_CORE_STAT, 16'h6000);
    fetch(24'h801050, ew(24'h801050, 1), 4);
    fetch(24'h801054, ew(24'h801054, 1), 0);
    wr(icache_pkg::REG_CONFIG, 16'h0003);
    rd(icache_pkg::REG_CONFIG);
    chk(v, 16'h0002, "config clamp");
    // One RAM set only: the second set's range now misses into the two-way cache
    wr(icache_pkg::REG_CONFIG, 16'h0001);
    fetch(24'h802FF8, ew(24'h802FF8, 1), 4);
    // Reloading a ready set must drop its tag-ok flag before the fill
    preload(icache_pkg::REG_RS1_TAG, icache_pkg::REG_RS1_CTRL, 16'h0801);
    fetch(24'h8010C4, ew(24'h8010C4, 1), 0);
    $display("test ram sets done");
    results;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(60000 * 20);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end
endmodule
`default_nettype wire
